// File: rtl/bec_top.sv
`timescale 1ns/10ps
module bec_top
    import bec_pkg::*;
#(
    parameter int HOLD_CYC = bec_pkg::BUS_INIT_HOLD_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [bec_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [bec_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [bec_pkg::DATA_W-1:0] reg_rdata,
    input wire bec_pkg::bec_err_t err_in,
    input wire logic bus_init_req,
    input wire bec_pkg::bec_freq_strap_t freq_strap,
    output bec_pkg::bec_err_t err_checked,
    output logic machine_check_error_out,
    output logic bus_initialise_out,
    output logic bus_initialise_out_oe,
    output logic request_count_encoding_en,
    output logic irq
);
    import bec_pkg::*;

    // =====================================================================
    // register state
    logic [SPO_W-1:0] spo_ff;
    logic [EV_W-1:0] mask_ff;
    logic [DATA_W-1:0] rdata_ff;
    bec_freq_strap_t strap_ff;
    logic strap_taken_ff;
    logic [DATA_W-1:0] freq_word;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] nxt_clear;
    logic [EV_W-1:0] events;

    wire wr_spo = reg_wr && (reg_addr == ADDR_SOFT_POWERON);
    wire wr_mask = reg_wr && (reg_addr == ADDR_IRQ_MASK);
    wire wr_status = reg_wr && (reg_addr == ADDR_IRQ_STATUS);

    // only the low seven bits are stored; upper bits are dropped on write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            spo_ff <= SPO_RESET;
        end else if (wr_spo) begin
            spo_ff <= reg_wdata[SPO_W-1:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_ff <= EV_ZERO;
        end else if (wr_mask) begin
            mask_ff <= reg_wdata[EV_W-1:0];
        end
    end

    // =====================================================================
    // strap capture: pins are sampled on the first edge after reset release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_taken_ff <= 1'b0;
            strap_ff <= '0;
        end else if (!strap_taken_ff) begin
            strap_taken_ff <= 1'b1;
            strap_ff <= freq_strap;
        end
    end

    // older models report only the ratio; the speed field reads as zero
    always_comb begin
        freq_word = '0;
        if (strap_ff.model >= FREQ_NEW_LAYOUT_MODEL) begin
            freq_word[FREQ_SPEED_LSB +: FREQ_SPEED_W] = strap_ff.bus_speed;
            freq_word[FREQ_RATIO_LSB +: FREQ_RATIO_W] = strap_ff.core_ratio;
        end else begin
            freq_word[FREQ_OLD_RATIO_LSB +: FREQ_RATIO_W] = strap_ff.core_ratio;
        end
    end

    // =====================================================================
    // read port: data stand in the cycle after the strobe only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ADDR_SOFT_POWERON: rdata_ff <= {{(DATA_W-SPO_W){1'b0}}, spo_ff};
                ADDR_FREQ_CONFIG: rdata_ff <= freq_word;
                ADDR_IRQ_STATUS: rdata_ff <= {{(DATA_W-EV_W){1'b0}}, status};
                ADDR_IRQ_MASK: rdata_ff <= {{(DATA_W-EV_W){1'b0}}, mask_ff};
                default: rdata_ff <= '0;
            endcase
        end else begin
            rdata_ff <= '0;
        end
    end

    assign reg_rdata = rdata_ff;

    // =====================================================================
    // error checking gates
    bec_err_t chk_ff;
    logic mce_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chk_ff <= '0;
        end else begin
            chk_ff.data_parity <= err_in.data_parity && !spo_ff[SPO_DATA_CHK_DIS_BIT];
            chk_ff.response <= err_in.response && !spo_ff[SPO_RESP_CHK_DIS_BIT];
            chk_ff.request <= err_in.request && !spo_ff[SPO_ADDR_CHK_DIS_BIT];
            chk_ff.initiator <= err_in.initiator && !spo_ff[SPO_INIT_MCE_DIS_BIT];
            chk_ff.internal <= err_in.internal && !spo_ff[SPO_INT_MCE_DIS_BIT];
        end
    end

    assign err_checked = chk_ff;

    // machine check is fed only by the initiator and internal gates; checked bus errors do not reach it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mce_ff <= 1'b0;
        end else begin
            mce_ff <= (err_in.initiator && !spo_ff[SPO_INIT_MCE_DIS_BIT])
                || (err_in.internal && !spo_ff[SPO_INT_MCE_DIS_BIT]);
        end
    end

    assign machine_check_error_out = mce_ff;

    // =====================================================================
    // bus-initialisation driver, held long enough for other agents to see it
    logic [HOLD_CNT_W-1:0] hold_ff;
    logic bus_initialise_out_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_ff <= '0;
        end else if (bus_init_req && !spo_ff[SPO_BUS_INITIALISE_OUT_DRV_DIS_BIT]) begin
            hold_ff <= HOLD_CNT_W'(HOLD_CYC);
        end else if (hold_ff != '0) begin
            hold_ff <= hold_ff - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_initialise_out_ff <= 1'b0;
        end else begin
            bus_initialise_out_ff <= !spo_ff[SPO_BUS_INITIALISE_OUT_DRV_DIS_BIT]
                && (bus_init_req || hold_ff > HOLD_CNT_W'(1));
        end
    end

    // the pin is driven only while asserting; otherwise it is released
    assign bus_initialise_out = bus_initialise_out_ff;
    assign bus_initialise_out_oe = bus_initialise_out_ff;

    assign request_count_encoding_en = spo_ff[SPO_REQ_COUNT_BIT];

    // driver level one cycle back, so the status bit marks only a rising edge
    logic bus_initialise_out_prev_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_initialise_out_prev_ff <= 1'b0;
        end else begin
            bus_initialise_out_prev_ff <= bus_initialise_out_ff;
        end
    end

    // =====================================================================
    // interrupt status
    always_comb begin
        events = EV_ZERO;
        events[EV_DATA_PARITY] = chk_ff.data_parity;
        events[EV_RESPONSE] = chk_ff.response;
        events[EV_REQUEST] = chk_ff.request;
        events[EV_MACHINE_CHECK] = mce_ff;
        events[EV_BUS_INIT] = bus_initialise_out_ff && !bus_initialise_out_prev_ff;
        nxt_clear = wr_status ? reg_wdata[EV_W-1:0] : EV_ZERO;
    end

    bec_sticky #(
        .WIDTH(EV_W)
    ) u_sticky (
        .clk(clk),
        .rst(rst),
        .set_evt(events),
        .clr_w1c(nxt_clear),
        .enable(mask_ff),
        .status(status),
        .irq(irq)
    );
endmodule

// File: rtl/bec_pkg.sv
package bec_pkg;
    // =====================================================================
    // register addresses
    localparam logic [7:0] ADDR_SOFT_POWERON = 8'h2b;
    localparam logic [7:0] ADDR_FREQ_CONFIG = 8'h2c;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h30;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h31;

    localparam int DATA_W = 64;
    localparam int ADDR_W = 8;

    // =====================================================================
    // soft power-on configuration fields
    localparam int SPO_REQ_COUNT_BIT = 0;
    localparam int SPO_DATA_CHK_DIS_BIT = 1;
    localparam int SPO_RESP_CHK_DIS_BIT = 2;
    localparam int SPO_ADDR_CHK_DIS_BIT = 3;
    localparam int SPO_INIT_MCE_DIS_BIT = 4;
    localparam int SPO_INT_MCE_DIS_BIT = 5;
    localparam int SPO_BUS_INITIALISE_OUT_DRV_DIS_BIT = 6;
    localparam int SPO_W = 7;
    localparam logic [SPO_W-1:0] SPO_RESET = 7'h7c;

    // =====================================================================
    // frequency configuration fields
    localparam logic [3:0] FREQ_NEW_LAYOUT_MODEL = 4'h2;
    localparam int FREQ_SPEED_LSB = 16;
    localparam int FREQ_SPEED_W = 3;
    localparam int FREQ_RATIO_LSB = 24;
    localparam int FREQ_RATIO_W = 8;
    localparam int FREQ_OLD_RATIO_LSB = 24;

    // =====================================================================
    // interrupt status bits
    localparam int EV_DATA_PARITY = 0;
    localparam int EV_RESPONSE = 1;
    localparam int EV_REQUEST = 2;
    localparam int EV_MACHINE_CHECK = 3;
    localparam int EV_BUS_INIT = 4;
    localparam int EV_W = 5;
    localparam logic [EV_W-1:0] EV_ZERO = 5'h00;

    // =====================================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int BUS_INIT_HOLD_NS = 20;
    localparam int BUS_INIT_HOLD_CYC =
        (BUS_INIT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CNT_W = 4;

    // =====================================================================
    // carriers
    typedef struct packed {
        logic data_parity;
        logic response;
        logic request;
        logic initiator;
        logic internal;
    } bec_err_t;

    typedef struct packed {
        logic [3:0] model;
        logic [FREQ_SPEED_W-1:0] bus_speed;
        logic [FREQ_RATIO_W-1:0] core_ratio;
    } bec_freq_strap_t;
endpackage

// File: rtl/bec_sticky.sv
`timescale 1ns/10ps
// =====================================================================
// sticky event bits, write-one-to-clear, masked onto one level
module bec_sticky #(
    parameter int WIDTH = 5
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] set_evt,
    input wire logic [WIDTH-1:0] clr_w1c,
    input wire logic [WIDTH-1:0] enable,
    output logic [WIDTH-1:0] status,
    output logic irq
);
    logic [WIDTH-1:0] status_ff;

    // set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_ff <= '0;
        end else begin
            status_ff <= (status_ff & ~clr_w1c) | set_evt;
        end
    end

    assign status = status_ff;
    assign irq = |(status_ff & enable);
endmodule

// File: testbench/bec_checker.sv
`timescale 1ns/10ps
// =====
// port-level checks of the bus error control block
module bec_checker
    import bec_pkg::*;
#(
    parameter int HOLD_CYC = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [bec_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [bec_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [bec_pkg::DATA_W-1:0] reg_rdata,
    input wire bec_pkg::bec_err_t err_in,
    input wire logic bus_init_req,
    input wire bec_pkg::bec_freq_strap_t freq_strap,
    input wire bec_pkg::bec_err_t err_checked,
    input wire logic machine_check_error_out,
    input wire logic bus_initialise_out,
    input wire logic bus_initialise_out_oe,
    input wire logic request_count_encoding_en,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_par_cause: assert property (err_checked.data_parity |-> $past(err_in.data_parity))
        else $error("parity flag without cause");
    a_resp_cause: assert property (err_checked.response |-> $past(err_in.response))
        else $error("response flag without cause");
    a_req_cause: assert property (err_checked.request |-> $past(err_in.request))
        else $error("request flag without cause");
    // both sources may drive the output, so only the union is checked here
    a_mce_cause: assert property (
        machine_check_error_out |-> $past(err_in.initiator || err_in.internal))
        else $error("machine check without cause");
    a_init_oe: assert property (bus_initialise_out_oe == bus_initialise_out)
        else $error("bus init enable differs from value");
    a_init_cause: assert property ($rose(bus_initialise_out) |-> $past(bus_init_req))
        else $error("bus init without request");
    // the repetition count is the default hold of two cycles plus one
    a_init_hold: assert property (
        bus_init_req ##1 !bus_init_req [*3] |-> !bus_initialise_out)
        else $error("bus init held too long");
    a_rd_once: assert property (reg_rdata != 64'h0 |-> $past(reg_rd))
        else $error("read data outside read slot");
    a_freq_new: assert property (
        reg_rd && reg_addr == ADDR_FREQ_CONFIG && freq_strap.model >= FREQ_NEW_LAYOUT_MODEL
        |=> reg_rdata == {32'h0, freq_strap.core_ratio, 5'h0, freq_strap.bus_speed, 16'h0})
        else $error("frequency layout wrong");
    a_freq_old: assert property (
        reg_rd && reg_addr == ADDR_FREQ_CONFIG && freq_strap.model < FREQ_NEW_LAYOUT_MODEL
        |=> reg_rdata == {32'h0, freq_strap.core_ratio, 24'h0})
        else $error("old frequency layout wrong");
    a_rce_cause: assert property ($rose(request_count_encoding_en) |->
        $past(reg_wr && reg_addr == ADDR_SOFT_POWERON && reg_wdata[0]))
        else $error("request count enable without write");
    c_mce: cover property (machine_check_error_out);
    c_init: cover property ($rose(bus_initialise_out));
    c_irq: cover property (irq);
endmodule

bind bec_top bec_checker #(.HOLD_CYC(HOLD_CYC)) bec_checker_i (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .err_in(err_in), .bus_init_req(bus_init_req),
    .freq_strap(freq_strap), .err_checked(err_checked),
    .machine_check_error_out(machine_check_error_out), .bus_initialise_out(bus_initialise_out),
    .bus_initialise_out_oe(bus_initialise_out_oe),
    .request_count_encoding_en(request_count_encoding_en), .irq(irq));

// File: testbench/bec_agent.sv
`timescale 1ns/10ps
// =====
// far-side bus agent: one-cycle error events and bus-init requests
module bec_agent
    import bec_pkg::*;
(
    input wire logic clk,
    output bec_pkg::bec_err_t err_in,
    output logic bus_init_req
);
    initial begin
        err_in = '0;
        bus_init_req = 1'b0;
    end
    task raise(input bec_err_t e);
        @(posedge clk);
        err_in <= e;
        @(posedge clk);
        err_in <= '0;
    endtask
    task pulse;
        @(posedge clk);
        bus_init_req <= 1'b1;
        @(posedge clk);
        bus_init_req <= 1'b0;
    endtask
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import bec_pkg::*;
    logic clk, rst, reg_wr, reg_rd, bus_init_req, mce, bio, bio_oe, rce, irq;
    logic [7:0] reg_addr;
    logic [63:0] reg_wdata, reg_rdata;
    bec_err_t err_in, err_checked;
    bec_freq_strap_t freq_strap;
    int n_errors = 0;
    int compares = 0;
    bec_top #(.HOLD_CYC(2)) bec_top_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .err_in(err_in), .bus_init_req(bus_init_req), .freq_strap(freq_strap),
        .err_checked(err_checked), .machine_check_error_out(mce), .bus_initialise_out(bio),
        .bus_initialise_out_oe(bio_oe), .request_count_encoding_en(rce), .irq(irq));
    bec_agent bec_agent_i (.clk(clk), .err_in(err_in), .bus_init_req(bus_init_req));
    // =====
    // tasks
    task cmp_w(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task cmp_b(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t bit %b expected %b", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [63:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task rd(input logic [7:0] a, input logic [63:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 cmp_w(reg_rdata, exp);
    endtask
    task err_case(input logic [63:0] spo, input bec_err_t e, input logic [63:0] chk,
        input logic m);
        wr(ADDR_SOFT_POWERON, spo);
        bec_agent_i.raise(e);
        #1 cmp_w(64'(err_checked), chk);
        cmp_b(mce, m);
    endtask
    task end_of_test;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // =====
    // clock, watchdog, tests
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        n_errors++;
        end_of_test();
    end
    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 64'h0;
        freq_strap = '{model: 4'h2, bus_speed: 3'h3, core_ratio: 8'h5a};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rd(ADDR_SOFT_POWERON, 64'h7c);
        rd(ADDR_FREQ_CONFIG, 64'h5a03_0000);
        wr(ADDR_FREQ_CONFIG, '1);
        rd(ADDR_FREQ_CONFIG, 64'h5a03_0000);
        rd(8'h40, 64'h0);
        $display("test registers done");
        wr(ADDR_SOFT_POWERON, '1);
        #1 cmp_b(rce, 1'b1);
        rd(ADDR_SOFT_POWERON, 64'h7f);
        $display("test reserved done");
        err_case(64'h7c, 5'h1f, 64'h10, 1'b0);
        err_case(64'h00, 5'h1f, 64'h1f, 1'b1);
        cmp_b(rce, 1'b0);
        err_case(64'h02, 5'h1f, 64'h0f, 1'b1);
        err_case(64'h6c, 5'h01, 64'h00, 1'b0);
        err_case(64'h6c, 5'h02, 64'h02, 1'b1);
        err_case(64'h5c, 5'h02, 64'h00, 1'b0);
        err_case(64'h5c, 5'h01, 64'h01, 1'b1);
        cmp_b(irq, 1'b0);
        rd(ADDR_IRQ_STATUS, 64'h0f);
        wr(ADDR_IRQ_MASK, 64'h1f);
        #1 cmp_b(irq, 1'b1);
        wr(ADDR_IRQ_STATUS, 64'h0f);
        #1 cmp_b(irq, 1'b0);
        $display("test errors done");
        wr(ADDR_SOFT_POWERON, 64'h40);
        bec_agent_i.pulse();
        @(posedge clk);
        #1 cmp_b(bio_oe, 1'b0);
        wr(ADDR_SOFT_POWERON, 64'h00);
        bec_agent_i.pulse();
        @(posedge clk);
        #1 cmp_b(bio, 1'b1);
        cmp_b(bio_oe, 1'b1);
        repeat (2) @(posedge clk);
        #1 cmp_b(bio, 1'b0);
        cmp_b(irq, 1'b1);
        rd(ADDR_IRQ_STATUS, 64'h10);
        $display("test bus init done");
        @(posedge clk);
        rst <= 1'b1;
        freq_strap <= '{model: 4'h1, bus_speed: 3'h3, core_ratio: 8'h5a};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rd(ADDR_FREQ_CONFIG, 64'h5a00_0000);
        rd(ADDR_SOFT_POWERON, 64'h7c);
        $display("test old layout done");
        end_of_test();
    end
endmodule
